// >>> lpcdec_top.sv
// Purpose: Legacy I/O range decoder steering host cycles to the LPC side
// Assumes: One cycle request per clock, synchronous inputs, 40 MHz clock
// Notes:   Decode result appears one clock after the request
//
// Behaviour
// [R1] Floppy select bit picks primary or secondary set
// [R2] Parallel field picks one of three sets
// [R3] Port 279h is read-only in 278h set
// [R4] Wave codec field picks one of four sets
// [R5] Music bit picks 330h or 300h pair
// [R6] Legacy sound field picks one of four sets
// [R7] Generic window: 128-byte aligned, I/O only
// [R8] Generic hit needs upper address bits zero
// [R9] Generic window forwarded only when enabled
// [R10] Bit 13 forwards ports 4Eh and 4Fh
// [R11] Bit 12 forwards ports 2Eh and 2Fh
// [R12] Bit 11 forwards ports 62h and 66h
// [R13] Bit 10 forwards ports 60h and 64h
// [R14] Bits 9 and 8 forward gameport halves
// [R15] Bit 7 forwards FM ports 388h-38Bh
// [R16] Bits 6,5,4 forward the selected sound ranges
// [R17] Bits 3,2 forward floppy and parallel ranges
// [R18] Bits 1,0 forward the serial port ranges
// [R19] Clear positive-only bit enables subtractive forwarding
// [R20] Unmatched cycles unclaimed; multiple hits forward once
`timescale 1ns/1ps
module lpcdec_top
  import lpcdec_pkg::*;
(
  input  wire logic                        clock_i,              // Core clock
  input  wire logic                        rst_n_i,              // Sync reset, low
  input  wire lpcdec_pkg::lpcdec_cfg_req_t cfg_i,                // Config access
  output logic [7:0]                       cfg_rdata_o,          // Config read data
  input  wire lpcdec_pkg::lpcdec_io_req_t  req_i,                // Host cycle
  input  wire logic                        other_claim_i,        // Claimed elsewhere
  input  wire logic                        positive_only_decode_i, // No subtractive
  input  wire logic                        serial_one_match_i,   // Serial 1 range hit
  input  wire logic                        serial_two_match_i,   // Serial 2 range hit
  output lpcdec_pkg::lpcdec_res_t          res_o,                // Decode result
  output logic [14:0]                      range_hits_o          // Per-range hits
);
  import lpcdec_pkg::*;

  // ------------------------------------------------------------
  // Configuration registers
  // ------------------------------------------------------------
  logic [7:0]  flp_par_r, flp_par_nxt;   // Floppy / parallel select
  logic [7:0]  snd_r,     snd_nxt;       // Sound range select
  logic [15:0] gen_r,     gen_nxt;       // Generic window one
  logic [15:0] en_r,      en_nxt;        // Range enables
  logic [7:0]  rdata_nxt;                // Read data next

  // Byte writes and read mux
  always_comb begin
    flp_par_nxt = flp_par_r;
    snd_nxt     = snd_r;
    gen_nxt     = gen_r;
    en_nxt      = en_r;
    rdata_nxt   = cfg_rdata_o;
    if (cfg_i.wr) begin
      unique case (cfg_i.addr)
        OFS_FLP_PAR: flp_par_nxt = cfg_i.wdata & FLP_PAR_MASK;
        OFS_SND:     snd_nxt     = cfg_i.wdata & SND_MASK;
        OFS_GEN_LO:  gen_nxt[7:0]  = cfg_i.wdata & GEN_MASK[7:0];
        OFS_GEN_HI:  gen_nxt[15:8] = cfg_i.wdata & GEN_MASK[15:8];
        OFS_EN_LO:   en_nxt[7:0]   = cfg_i.wdata & EN_MASK[7:0];
        OFS_EN_HI:   en_nxt[15:8]  = cfg_i.wdata & EN_MASK[15:8];
        default: ;   // Unmapped offsets ignore writes
      endcase
    end
    if (cfg_i.rd) begin
      unique case (cfg_i.addr)
        OFS_FLP_PAR: rdata_nxt = flp_par_r;
        OFS_SND:     rdata_nxt = snd_r;
        OFS_GEN_LO:  rdata_nxt = gen_r[7:0];
        OFS_GEN_HI:  rdata_nxt = gen_r[15:8];
        OFS_EN_LO:   rdata_nxt = en_r[7:0];
        OFS_EN_HI:   rdata_nxt = en_r[15:8];
        default:     rdata_nxt = 8'h00;  // Unmapped reads zero
      endcase
    end
  end

  // Register stage, all ranges off after reset
  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      flp_par_r   <= FLP_PAR_RST;
      snd_r       <= SND_RST;
      gen_r       <= GEN_RST;
      en_r        <= EN_RST;
      cfg_rdata_o <= 8'h00;
    end else begin
      flp_par_r   <= flp_par_nxt;
      snd_r       <= snd_nxt;
      gen_r       <= gen_nxt;
      en_r        <= en_nxt;
      cfg_rdata_o <= rdata_nxt;
    end
  end

  // ------------------------------------------------------------
  // Address decode
  // ------------------------------------------------------------
  // Inclusive range test
  function automatic logic in_rng(input logic [15:0] a,
                                  input logic [15:0] lo,
                                  input logic [15:0] span);
    in_rng = (a >= lo) && (a <= 16'(lo + span));
  endfunction

  logic [15:0] a16;        // Low I/O address
  logic        io_ok;      // Valid I/O cycle, upper lines zero
  logic [1:0]  par_sel;    // Parallel set code
  logic [1:0]  wave_sel;   // Wave codec set code
  logic [1:0]  leg_sel;    // Legacy sound set code
  logic        flp_sel;    // Floppy set select
  logic        mus_sel;    // Music pair select
  logic [15:0] flp_lo;     // Selected floppy base
  logic [15:0] par_lo;     // Selected parallel base
  logic [15:0] par_span;   // Selected parallel span
  logic [13:0] hit_raw;    // Fixed hits before enables
  logic        gen_raw;    // Generic window match
  logic [14:0] hit_nxt;    // Gated hits
  logic        pos_hit;    // Any positive hit
  lpcdec_res_t res_nxt;    // Next result
  logic [14:0] hits_r;     // Registered hits

  always_comb begin
    a16      = req_i.addr[15:0];
    io_ok    = req_i.valid && req_i.is_io && (req_i.addr[31:16] == 16'h0000); // [R8]
    par_sel  = flp_par_r[PAR_SEL_LSB +: 2];
    wave_sel = snd_r[WAVE_SEL_LSB +: 2];
    leg_sel  = snd_r[LEG_SEL_LSB +: 2];
    flp_sel  = flp_par_r[FLP_SEL_BIT];
    mus_sel  = snd_r[MUS_SEL_BIT];
    flp_lo   = FLP_LO[flp_sel];                       // [R1]
    par_lo   = (par_sel == PAR_RSVD) ? 16'h0000 : PAR_LO[par_sel];
    par_span = (par_sel == PAR_RSVD) ? 16'h0000 : PAR_SPAN[par_sel];
    hit_raw  = '0;
    // Fixed single ports
    hit_raw[EN_CNF2] = (a16 == CNF2_A) || (a16 == CNF2_B);   // [R10]
    hit_raw[EN_CNF1] = (a16 == CNF1_A) || (a16 == CNF1_B);   // [R11]
    hit_raw[EN_EC]   = (a16 == EC_A) || (a16 == EC_B);       // [R12]
    hit_raw[EN_KBC]  = (a16 == KBC_A) || (a16 == KBC_B);     // [R13]
    // Fixed ranges
    hit_raw[EN_GMH]  = (a16 >= GMH_LO) && (a16 <= GMH_HI);   // [R14]
    hit_raw[EN_GML]  = (a16 >= GML_LO) && (a16 <= GML_HI);   // [R14]
    hit_raw[EN_FM]   = (a16 >= FM_LO) && (a16 <= FM_HI);     // [R15]
    // Sound ranges chosen by the sound select register
    hit_raw[EN_WAVE] = in_rng(a16, WAVE_LO[wave_sel], WAVE_SPAN); // [R4]
    hit_raw[EN_MUS]  = in_rng(a16, MUS_LO[mus_sel], MUS_SPAN);    // [R5]
    hit_raw[EN_LEG]  = in_rng(a16, LEG_LO[leg_sel], LEG_SPAN);    // [R6]
    // Floppy: base span plus the extra port
    hit_raw[EN_FLP]  = in_rng(a16, flp_lo, FLP_SPAN)
                    || (a16 == 16'(flp_lo + FLP_XTRA));           // [R1]
    // Parallel: low set plus its 400h alias, reserved code decodes nothing
    hit_raw[EN_PAR]  = (par_sel != PAR_RSVD)
                    && (in_rng(a16, par_lo, par_span)
                    ||  in_rng(a16, 16'(par_lo + PAR_HI_OFS), par_span)); // [R2]
    // Read-only port: writes to it get no parallel range hit
    if ((par_sel == PAR_RO_SET) && req_i.write && (a16 == PAR_RO_PORT)) begin
      hit_raw[EN_PAR] = 1'b0;                                     // [R3]
    end
    hit_raw[EN_SER2] = serial_two_match_i;                        // [R18]
    hit_raw[EN_SER1] = serial_one_match_i;                        // [R18]
    // Generic 128-byte window, compare bits 15:7 only
    gen_raw = (a16[15:GEN_BASE_LSB] == gen_r[15:GEN_BASE_LSB]);   // [R7]
    // Gate by enables
    hit_nxt[13:0]   = io_ok ? (hit_raw & en_r[13:0]) : 14'h0000;  // [R16] [R17]
    hit_nxt[HIT_GEN] = io_ok && gen_raw && gen_r[GEN_EN_BIT];     // [R9]
    // Any hit claims once, never more
    pos_hit = |hit_nxt;                                           // [R20]
    res_nxt.done        = req_i.valid;
    res_nxt.positive    = pos_hit;
    // Unclaimed cycles pass on only in subtractive mode
    res_nxt.subtractive = req_i.valid && !pos_hit && !other_claim_i
                       && !positive_only_decode_i;                // [R19]
    res_nxt.forward     = res_nxt.positive || res_nxt.subtractive; // [R20]
  end

  // Result stage
  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      res_o  <= '0;
      hits_r <= '0;
    end else begin
      res_o  <= res_nxt;
      hits_r <= hit_nxt;
    end
  end

  assign range_hits_o = hits_r;

  // ------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!rst_n_i);

  // Write cycle to the read-only port in the 278h set
  sequence s_ro_write;
    req_i.valid && req_i.is_io && req_i.write && (req_i.addr == 32'h0000_0279)
      && (flp_par_r[1:0] == PAR_RO_SET);
  endsequence

  // Keyboard port with its enable set
  sequence s_kbc_cycle;
    req_i.valid && req_i.is_io && (req_i.addr == 32'h0000_0064) && en_r[EN_KBC];
  endsequence

  a_ro_port_write: assert property (s_ro_write |=> !range_hits_o[EN_PAR]) // [R3]
    else $error("write to read-only parallel port decoded");
  a_kbc_port_hit: assert property (s_kbc_cycle |=> range_hits_o[EN_KBC] && res_o.forward) // [R13]
    else $error("keyboard port not forwarded");
  a_gen_mem_cycle: assert property (req_i.valid && !req_i.is_io |=> range_hits_o == 15'h0) // [R7]
    else $error("memory cycle matched an I/O range");
  a_gen_upper_bits: assert property (req_i.addr[31:16] != 16'h0 |=> !range_hits_o[HIT_GEN]) // [R8]
    else $error("generic hit with upper address set");
  a_gen_win_off: assert property (!gen_r[GEN_EN_BIT] |=> !range_hits_o[HIT_GEN]) // [R9]
    else $error("generic window hit while disabled");
  a_par_rsvd_code: assert property (flp_par_r[1:0] == PAR_RSVD |=> !range_hits_o[EN_PAR]) // [R2]
    else $error("reserved parallel code decoded");
  a_sub_mode_gate: assert property (res_o.subtractive |-> !$past(positive_only_decode_i)) // [R19]
    else $error("subtractive forward in positive-only mode");
  a_fwd_once_only: assert property (res_o.done |-> !(res_o.positive && res_o.subtractive)) // [R20]
    else $error("cycle claimed twice");
  // All ranges off: nothing may be claimed positively
  a_no_hit_claim: assert property (req_i.valid && en_r == 16'h0 && !gen_r[GEN_EN_BIT] // [R20]
                                   |=> !res_o.positive && (range_hits_o == 15'h0))
    else $error("claim without an enabled range");
  // No result without a request, so no forward without a host cycle
  a_fwd_needs_req: assert property (!req_i.valid |=> !res_o.done && !res_o.forward) // [R20]
    else $error("forward without a host cycle");
  a_en_reg_read: assert property (cfg_i.rd && cfg_i.addr == OFS_EN_HI && !cfg_i.wr
                                  |=> cfg_rdata_o == {2'b00, $past(en_r[13:8])}) // [R10] [R11] [R12] [R13] [R14]
    else $error("enable register read mismatch");

endmodule

// >>> lpcdec_pkg.sv
// Purpose: Constants and carrier types for the LPC I/O range decoder
// Assumes: Byte-wide configuration access, 16-bit legacy I/O space
// Notes:   Each offset, field position, reset value and range base named once
package lpcdec_pkg;
  // ------------------------------------------------------------
  // Configuration offsets
  // ------------------------------------------------------------
  localparam logic [7:0] OFS_FLP_PAR = 8'hE1;
  localparam logic [7:0] OFS_SND     = 8'hE2;
  localparam logic [7:0] OFS_GEN_LO  = 8'hE4;
  localparam logic [7:0] OFS_GEN_HI  = 8'hE5;
  localparam logic [7:0] OFS_EN_LO   = 8'hE6;
  localparam logic [7:0] OFS_EN_HI   = 8'hE7;
  // ------------------------------------------------------------
  // Reset values and implemented-bit masks
  // ------------------------------------------------------------
  localparam logic [7:0]  FLP_PAR_RST  = 8'h00;
  localparam logic [7:0]  SND_RST      = 8'h00;
  localparam logic [15:0] GEN_RST      = 16'h0000;
  localparam logic [15:0] EN_RST       = 16'h0000;
  localparam logic [7:0]  FLP_PAR_MASK = 8'h13;
  localparam logic [7:0]  SND_MASK     = 8'h3B;
  localparam logic [15:0] GEN_MASK     = 16'hFF81;
  localparam logic [15:0] EN_MASK      = 16'h3FFF;
  // ------------------------------------------------------------
  // Field positions
  // ------------------------------------------------------------
  localparam int FLP_SEL_BIT  = 4;
  localparam int PAR_SEL_LSB  = 0;
  localparam int WAVE_SEL_LSB = 4;
  localparam int MUS_SEL_BIT  = 3;
  localparam int LEG_SEL_LSB  = 0;
  localparam int GEN_BASE_LSB = 7;
  localparam int GEN_EN_BIT   = 0;
  localparam int EN_CNF2 = 13;
  localparam int EN_CNF1 = 12;
  localparam int EN_EC   = 11;
  localparam int EN_KBC  = 10;
  localparam int EN_GMH  = 9;
  localparam int EN_GML  = 8;
  localparam int EN_FM   = 7;
  localparam int EN_WAVE = 6;
  localparam int EN_MUS  = 5;
  localparam int EN_LEG  = 4;
  localparam int EN_FLP  = 3;
  localparam int EN_PAR  = 2;
  localparam int EN_SER2 = 1;
  localparam int EN_SER1 = 0;
  localparam int HIT_GEN = 14;
  // ------------------------------------------------------------
  // Fixed and selectable I/O ranges
  // ------------------------------------------------------------
  localparam logic [15:0] CNF2_A = 16'h004E, CNF2_B = 16'h004F;
  localparam logic [15:0] CNF1_A = 16'h002E, CNF1_B = 16'h002F;
  localparam logic [15:0] EC_A   = 16'h0062, EC_B   = 16'h0066;
  localparam logic [15:0] KBC_A  = 16'h0060, KBC_B  = 16'h0064;
  localparam logic [15:0] GMH_LO = 16'h0208, GMH_HI = 16'h020F;
  localparam logic [15:0] GML_LO = 16'h0200, GML_HI = 16'h0207;
  localparam logic [15:0] FM_LO  = 16'h0388, FM_HI  = 16'h038B;
  localparam logic [3:0][15:0] WAVE_LO = {16'h0F40, 16'h0E80, 16'h0604, 16'h0530};
  localparam logic [15:0] WAVE_SPAN = 16'h0007;
  localparam logic [3:0][15:0] LEG_LO = {16'h0280, 16'h0260, 16'h0240, 16'h0220};
  localparam logic [15:0] LEG_SPAN = 16'h0013;
  localparam logic [1:0][15:0] MUS_LO = {16'h0300, 16'h0330};
  localparam logic [15:0] MUS_SPAN = 16'h0001;
  localparam logic [1:0][15:0] FLP_LO = {16'h0370, 16'h03F0};
  localparam logic [15:0] FLP_SPAN = 16'h0005;
  localparam logic [15:0] FLP_XTRA = 16'h0007;
  localparam logic [2:0][15:0] PAR_LO = {16'h03BC, 16'h0278, 16'h0378};
  localparam logic [2:0][15:0] PAR_SPAN = {16'h0002, 16'h0007, 16'h0007};
  localparam logic [15:0] PAR_HI_OFS = 16'h0400;
  localparam logic [1:0]  PAR_RSVD   = 2'b11;
  localparam logic [1:0]  PAR_RO_SET = 2'b01;
  localparam logic [15:0] PAR_RO_PORT = 16'h0279;
  // ------------------------------------------------------------
  // Carriers
  // ------------------------------------------------------------
  typedef struct packed {
    logic        valid;
    logic        is_io;
    logic        write;
    logic [31:0] addr;
  } lpcdec_io_req_t;
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } lpcdec_cfg_req_t;
  typedef struct packed {
    logic done;
    logic forward;
    logic positive;
    logic subtractive;
  } lpcdec_res_t;
endpackage

// >>> lpcdec_peer.sv
// Purpose: Far-side model giving serial range matches and foreign claims
// Assumes: Legacy 16-bit I/O space, answers in the cycle of the request
// Notes:   Window bases are parameters with plain defaults
`timescale 1ns/1ps
module lpcdec_peer
  import lpcdec_pkg::*;
#(
  parameter logic [15:0] SER1_BASE  = 16'h03F8, // Serial one window
  parameter logic [15:0] SER2_BASE  = 16'h02F8, // Serial two window
  parameter logic [15:0] CLAIM_BASE = 16'h0CF8  // Other internal target
)(
  input  wire lpcdec_pkg::lpcdec_io_req_t req_i,         // Observed host cycle
  output logic                            other_claim_o, // Claimed elsewhere
  output logic                            serial_one_o,  // Serial one hit
  output logic                            serial_two_o   // Serial two hit
);
  import lpcdec_pkg::*;

  // ----------------------------------------------------------
  // Eight-port windows, I/O space below 64K only
  // ----------------------------------------------------------
  logic low_io; // Valid I/O cycle with upper lines zero
  always_comb begin
    low_io        = req_i.valid && req_i.is_io && (req_i.addr[31:16] == 16'h0000);
    serial_one_o  = low_io && (req_i.addr[15:3] == SER1_BASE[15:3]);
    serial_two_o  = low_io && (req_i.addr[15:3] == SER2_BASE[15:3]);
    other_claim_o = low_io && (req_i.addr[15:3] == CLAIM_BASE[15:3]);
  end
endmodule

// >>> lpcdec_top_tb.sv
// Purpose: Self-checking bench for the LPC I/O range decoder
// Assumes: Byte config port, one host cycle per request
// Notes:   Inputs move 1 ns after each rising edge
`timescale 1ns/1ps
module lpcdec_top_tb;
  import lpcdec_pkg::*;
  // ----------------------------------------------------------
  // Signals and tables
  // ----------------------------------------------------------
  logic            clock_i  = 1'b0; // 40 MHz core clock
  logic            rst_n_i  = 1'b0; // Sync reset, low
  lpcdec_cfg_req_t cfg      = '0;   // Config access
  lpcdec_io_req_t  req      = '0;   // Host cycle
  logic            pos_only = 1'b1; // No subtractive forwarding
  logic [7:0]      rdata;           // Config read data
  lpcdec_res_t     res;             // Decode result
  logic [14:0]     hits;            // Per-range hits
  logic            claim, ser1, ser2; // Far-side answers
  int              bad_count = 0, total_checks = 0, cycles = 0;
  logic [35:0]     e;               // Entry: hit bit, write, E1, E2, address
  logic [7:0]      msk [7] = '{8'h13, 8'h3B, 8'h00, 8'h81, 8'hFF, 8'hFF, 8'h3F};
  logic [35:0]     tbl [49] = '{
    36'h3_0_00_00_3F0, 36'h3_0_00_00_3F5, 36'h3_0_00_00_3F7, 36'hF_0_00_00_3F6,
    36'h3_0_10_00_370, 36'h3_0_10_00_377, 36'hF_0_10_00_376, 36'hF_0_10_00_3F0,
    36'h2_0_00_00_37F, 36'h2_0_00_00_778, 36'h2_0_01_00_27F, 36'h2_0_01_00_678,
    36'h2_0_02_00_3BE, 36'h2_0_02_00_7BC, 36'hF_0_02_00_3BF, 36'hF_0_03_00_378,
    36'hF_1_01_00_279, 36'h2_0_01_00_279, 36'h2_1_01_00_278,
    36'h6_0_00_00_530, 36'h6_0_00_10_60B, 36'h6_0_00_20_E80, 36'h6_0_00_30_F47,
    36'h5_0_00_00_331, 36'h5_0_00_08_300, 36'hF_0_00_08_330,
    36'h4_0_00_00_233, 36'h4_0_00_01_240, 36'h4_0_00_02_273, 36'h4_0_00_03_280,
    36'hF_0_00_03_294, 36'hD_0_00_00_04E, 36'hD_0_00_00_04F, 36'hC_0_00_00_02E,
    36'hC_0_00_00_02F, 36'hB_0_00_00_062, 36'hB_0_00_00_066, 36'hA_0_00_00_060,
    36'hA_0_00_00_064, 36'hF_0_00_00_063, 36'h9_0_00_00_20F, 36'h9_0_00_00_208,
    36'h8_0_00_00_200, 36'h8_0_00_00_207, 36'h7_0_00_00_38B, 36'h7_0_00_00_388,
    36'hF_0_00_00_38C, 36'h0_0_00_00_3F8, 36'h1_0_00_00_2FF};
  // ----------------------------------------------------------
  // Clock, design and far side
  // ----------------------------------------------------------
  always #12.5 clock_i = ~clock_i;
  lpcdec_top dut (.clock_i(clock_i), .rst_n_i(rst_n_i), .cfg_i(cfg), .cfg_rdata_o(rdata),
    .req_i(req), .other_claim_i(claim), .positive_only_decode_i(pos_only),
    .serial_one_match_i(ser1), .serial_two_match_i(ser2), .res_o(res), .range_hits_o(hits));
  lpcdec_peer peer (.req_i(req), .other_claim_o(claim), .serial_one_o(ser1),
    .serial_two_o(ser2));
  // ----------------------------------------------------------
  // Access tasks
  // ----------------------------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("MISMATCH at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask
  // Each access first lets an idle edge pass, so strobes never retrigger
  task automatic cfg_wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clock_i);
    #1;
    cfg = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge clock_i);
    #1;
    cfg = '0;
  endtask
  task automatic cfg_rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clock_i);
    #1;
    cfg = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
    @(posedge clock_i);
    #1;
    cfg = '0;
    check({24'h0, rdata}, {24'h0, exp});
  endtask
  // One host cycle; answer lands one edge later
  task automatic io(input logic [31:0] a, input logic isio, input logic w,
                    input logic [14:0] eh, input logic f);
    @(posedge clock_i);
    #1;
    req = '{valid: 1'b1, is_io: isio, write: w, addr: a};
    @(posedge clock_i);
    #1;
    req = '0;
    check({31'h0, res.done}, 32'h1);
    check({17'h0, hits}, {17'h0, eh});
    check({31'h0, res.forward}, {31'h0, f});
  endtask
  function automatic logic [14:0] hb(input logic [3:0] b);
    hb = (b == 4'hF) ? 15'h0000 : (15'h0001 << b);
  endfunction
  task automatic end_sim();
    $display("checks %0d, mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  // Hang guard
  always @(posedge clock_i) begin
    cycles++;
    if (cycles == 5000) begin
      bad_count++;
      end_sim();
    end
  end
  // ----------------------------------------------------------
  // Test sequence
  // ----------------------------------------------------------
  initial begin
    repeat (10) @(posedge clock_i);
    #1;
    rst_n_i = 1'b1;
    // Reset values, then reserved bits and unmapped offset
    for (int i = 0; i < 7; i++) begin
      cfg_rd(8'hE1 + 8'(i), 8'h00);
      cfg_wr(8'hE1 + 8'(i), 8'hFF);
      cfg_rd(8'hE1 + 8'(i), msk[i]);
    end
    $display("test registers done");
    cfg_wr(OFS_GEN_LO, 8'h00);
    // Pass 0 all ranges but the generic window enabled, pass 1 all disabled
    for (int p = 0; p < 2; p++) begin
      cfg_wr(OFS_EN_LO, p ? 8'h00 : 8'hFF);
      cfg_wr(OFS_EN_HI, p ? 8'h00 : 8'h3F);
      for (int i = 0; i < 49; i++) begin
        e = tbl[i];
        cfg_wr(OFS_FLP_PAR, e[27:20]);
        cfg_wr(OFS_SND, e[19:12]);
        io({20'h0, e[11:0]}, 1'b1, e[28], p ? 15'h0 : hb(e[35:32]),
           !p && (e[35:32] != 4'hF));
      end
      $display("test decode pass %0d done", p);
    end
    // Generic window at 1280h
    cfg_wr(OFS_EN_LO, 8'hFF);
    cfg_wr(OFS_EN_HI, 8'h3F);
    cfg_wr(OFS_GEN_LO, 8'h81);
    cfg_wr(OFS_GEN_HI, 8'h12);
    io(32'h1280, 1'b1, 1'b0, 15'h4000, 1'b1);
    io(32'h12FF, 1'b1, 1'b1, 15'h4000, 1'b1);
    io(32'h1300, 1'b1, 1'b0, 15'h0000, 1'b0);
    io(32'h127F, 1'b1, 1'b0, 15'h0000, 1'b0);
    io(32'h0001_1280, 1'b1, 1'b0, 15'h0000, 1'b0);
    io(32'h1280, 1'b0, 1'b0, 15'h0000, 1'b0);
    cfg_wr(OFS_GEN_LO, 8'h80);
    io(32'h1280, 1'b1, 1'b0, 15'h0000, 1'b0);
    cfg_wr(OFS_GEN_LO, 8'h01);
    cfg_wr(OFS_GEN_HI, 8'h00);
    io(32'h0060, 1'b1, 1'b0, 15'h4400, 1'b1);
    @(posedge clock_i);
    #1;
    check({31'h0, res.done}, 32'h0);
    $display("test generic window done");
    // Subtractive forwarding
    cfg_wr(OFS_GEN_LO, 8'h00);
    pos_only = 1'b0;
    io(32'h0063, 1'b1, 1'b0, 15'h0000, 1'b1);
    check({31'h0, res.subtractive}, 32'h1);
    io(32'h0060, 1'b1, 1'b0, 15'h0400, 1'b1);
    check({30'h0, res.positive, res.subtractive}, 32'h2);
    io(32'h0CF8, 1'b1, 1'b0, 15'h0000, 1'b0);
    io(32'h1000_0000, 1'b0, 1'b0, 15'h0000, 1'b1);
    pos_only = 1'b1;
    io(32'h0063, 1'b1, 1'b0, 15'h0000, 1'b0);
    $display("test subtractive done");
    end_sim();
  end
endmodule
